// ==== telephony_irq_dual_tone_signal_indirect_regs.sv ====
/*
  Interrupt status and enable registers, tone decoder status and the
  indirect data port with its update engine.
  Assumes a plain register port from software and event inputs that
  are synchronous to clk_i and one cycle long where they are pulses.
*/
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "telephony_irq_consts.svh"
module telephony_irq_dual_tone_signal_indirect_regs (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] timer_event_i,
  input  wire logic [7:0] alarm_event_i,
  input  wire logic       hook_state_i,
  input  wire logic       cal_active_i,
  input  wire logic       tone_valid_i,
  input  wire logic [3:0] tone_digit_i,
  output logic            irq_o
);
  telephony_irq_pkg::regs_type st;
  telephony_irq_pkg::regs_type next_st;

  logic        tick;
  logic        mem_we;
  logic        mem_re;
  logic [15:0] mem_rdata;
  logic        ind_done;
  logic        hook_change;
  logic        addr_write;
  logic [7:0]  clr_one;
  logic [7:0]  clr_two;
  logic [7:0]  clr_three;
  logic [7:0]  set_three;

  // ----------------------------------------------------------------
  // update tick and indirect store
  // ----------------------------------------------------------------
  indirect_update_tick u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick_o (tick)
  );

  indirect_store u_store (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .we_i    (mem_we),
    .re_i    (mem_re),
    .addr_i  (st.indirect_address),
    .wdata_i ({st.data_high, st.data_low}),
    .rdata_o (mem_rdata)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st     = st;
    mem_we      = 1'b0;
    mem_re      = 1'b0;
    ind_done    = 1'b0;
    addr_write  = wr_i && (addr_i == `ADDR_IND_ADDRESS);
    hook_change = hook_state_i != st.hook_prev;
    clr_one     = 8'h00;
    clr_two     = 8'h00;
    clr_three   = 8'h00;
    if (wr_i && addr_i == `ADDR_STATUS_ONE)
      clr_one = wdata_i;
    if (wr_i && addr_i == `ADDR_STATUS_TWO)
      clr_two = wdata_i;
    if (wr_i && addr_i == `ADDR_STATUS_THREE)
      clr_three = wdata_i;

    // indirect engine; a fresh address write restarts it
    case (st.phase)
      telephony_irq_pkg::IND_IDLE:
        next_st.phase = telephony_irq_pkg::IND_IDLE;
      telephony_irq_pkg::IND_WAIT_TICK:
      begin
        if (tick && !addr_write)
        begin
          mem_we        = st.op_write;
          mem_re        = !st.op_write;
          next_st.phase = telephony_irq_pkg::IND_FINISH;
        end
      end
      telephony_irq_pkg::IND_FINISH:
      begin
        if (!st.op_write)
        begin
          next_st.data_low  = mem_rdata[7:0];
          next_st.data_high = mem_rdata[15:8];
        end
        next_st.indirect_pending = 1'b0;
        ind_done                 = 1'b1;
        next_st.phase            = telephony_irq_pkg::IND_IDLE;
      end
      default:
        next_st.phase = telephony_irq_pkg::IND_IDLE;
    endcase

    // set wins over a clear in the same cycle
    set_three = {5'h00,
                 cal_active_i && hook_change,
                 ind_done,
                 tone_valid_i && !st.digit_valid};
    next_st.status_one = (st.status_one & ~clr_one)
                       | timer_event_i;
    next_st.status_two = (st.status_two & ~clr_two)
                       | alarm_event_i;
    next_st.status_three = ((st.status_three & ~clr_three)
                           | set_three) & `THREE_MASK;

    next_st.hook_prev   = hook_state_i;
    next_st.digit_valid = tone_valid_i;
    if (tone_valid_i)
      next_st.decoded_digit = tone_digit_i;

    // software writes come last so they win over the engine
    if (wr_i)
    begin
      case (addr_i)
        `ADDR_ENABLE_ONE:
          next_st.enable_one = wdata_i;
        `ADDR_ENABLE_TWO:
          next_st.enable_two = wdata_i;
        `ADDR_ENABLE_THREE:
          next_st.enable_three = wdata_i & `THREE_MASK;
        `ADDR_DATA_LOW:
        begin
          next_st.data_low   = wdata_i;
          next_st.data_dirty = 1'b1;
        end
        `ADDR_DATA_HIGH:
        begin
          next_st.data_high  = wdata_i;
          next_st.data_dirty = 1'b1;
        end
        `ADDR_IND_ADDRESS:
        begin
          next_st.indirect_address = wdata_i;
          next_st.indirect_pending = 1'b1;
          next_st.op_write         = st.data_dirty;
          next_st.data_dirty       = 1'b0;
          next_st.phase            = telephony_irq_pkg::IND_WAIT_TICK;
        end
        default:
          next_st.data_dirty = next_st.data_dirty;
      endcase
    end

    // read data stand only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `ADDR_STATUS_ONE:
          next_st.rdata = st.status_one;
        `ADDR_STATUS_TWO:
          next_st.rdata = st.status_two;
        `ADDR_STATUS_THREE:
          next_st.rdata = st.status_three & `THREE_MASK;
        `ADDR_ENABLE_ONE:
          next_st.rdata = st.enable_one;
        `ADDR_ENABLE_TWO:
          next_st.rdata = st.enable_two;
        `ADDR_ENABLE_THREE:
          next_st.rdata = st.enable_three & `THREE_MASK;
        `ADDR_TONE_STATUS:
          next_st.rdata = {3'h0, st.digit_valid,
                           st.decoded_digit};
        `ADDR_DATA_LOW:
          next_st.rdata = st.data_low;
        `ADDR_DATA_HIGH:
          next_st.rdata = st.data_high;
        `ADDR_IND_ADDRESS:
          next_st.rdata = st.indirect_address;
        `ADDR_IND_STATUS:
          next_st.rdata = {7'h00, st.indirect_pending};
        default:
          next_st.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign rdata_o = st.rdata;
  assign irq_o   = |(st.status_one & st.enable_one)
                 | |(st.status_two & st.enable_two)
                 | |(st.status_three & st.enable_three);

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // cycles of the running access; a fresh address write restarts
  // the access, so it restarts the count as well
  logic [10:0] pend_cycles;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pend_cycles <= 11'h000;
    else if (!st.indirect_pending || addr_write)
      pend_cycles <= 11'h000;
    else
      pend_cycles <= pend_cycles + 11'h001;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_cal_error_set: assert property (
    cal_active_i && hook_state_i != st.hook_prev
    |=> st.status_three[`CAL_ERROR_BIT])
    else $error("cal error flag not set on hook change");

  a_tone_flag_set: assert property (
    tone_valid_i && !st.digit_valid
    |=> st.status_three[`TONE_DETECT_BIT] ##0 st.digit_valid)
    else $error("tone flag not set on new digit");

  a_zero_write_keeps: assert property (
    wr_i && addr_i == `ADDR_STATUS_THREE && !wdata_i[0]
    && st.status_three[0] |=> st.status_three[0])
    else $error("zero write cleared a pending flag");

  a_one_write_clears: assert property (
    wr_i && addr_i == `ADDR_STATUS_THREE && wdata_i[2]
    && !(cal_active_i && hook_state_i != st.hook_prev)
    |=> !st.status_three[2])
    else $error("one write did not clear flag");

  a_irq_on_enabled: assert property (
    $rose(st.status_three[`IND_DONE_BIT])
    && st.enable_three[`IND_DONE_BIT] |-> irq_o)
    else $error("interrupt missing for enabled flag");

  a_pending_on_addr: assert property (
    wr_i && addr_i == `ADDR_IND_ADDRESS
    |=> st.indirect_pending ##1 st.indirect_pending)
    else $error("pending not raised by address write");

  a_done_follows: assert property (
    $fell(st.indirect_pending) |-> st.status_three[`IND_DONE_BIT])
    else $error("done flag missing after indirect access");

  a_access_bounded: assert property (
    pend_cycles < 11'(`IND_TICK_CYCLES + 8))
    else $error("indirect access not done within one tick");

  a_enable_readback: assert property (
    rd_i && addr_i == `ADDR_ENABLE_THREE
    |=> rdata_o == {5'h00, $past(st.enable_three[2:0])})
    else $error("enable three read back wrong");

  a_read_one_cycle: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside the answer cycle");

  a_valid_high: assert property (
    tone_valid_i |=> st.digit_valid)
    else $error("valid bit not raised while digit detected");

  a_valid_low: assert property (
    !tone_valid_i |=> !st.digit_valid)
    else $error("valid bit high with no digit detected");

  a_digit_latched: assert property (
    tone_valid_i |=> st.decoded_digit == $past(tone_digit_i))
    else $error("decoded digit not taken from the decoder");

  a_status_one_set: assert property (
    timer_event_i != 8'h00
    |=> (st.status_one & $past(timer_event_i)) == $past(timer_event_i))
    else $error("timer event did not set its pending flag");

  a_status_two_set: assert property (
    alarm_event_i != 8'h00
    |=> (st.status_two & $past(alarm_event_i)) == $past(alarm_event_i))
    else $error("alarm event did not set its pending flag");

  a_enable_one_write: assert property (
    wr_i && addr_i == `ADDR_ENABLE_ONE |=> st.enable_one == $past(wdata_i))
    else $error("enable one not written");

  a_enable_two_write: assert property (
    wr_i && addr_i == `ADDR_ENABLE_TWO |=> st.enable_two == $past(wdata_i))
    else $error("enable two not written");

  a_reserved_zero: assert property (
    st.status_three[7:3] == 5'h00 && st.enable_three[7:3] == 5'h00)
    else $error("reserved bits of status or enable three set");

  a_read_loads: assert property (
    st.phase == telephony_irq_pkg::IND_FINISH && !st.op_write
    && !(wr_i && (addr_i == `ADDR_DATA_LOW || addr_i == `ADDR_DATA_HIGH))
    |=> {st.data_high, st.data_low} == $past(mem_rdata))
    else $error("read access did not load the data bytes");

  a_pending_clears: assert property (
    st.phase == telephony_irq_pkg::IND_FINISH && !addr_write
    |=> !st.indirect_pending)
    else $error("pending still set after the access finished");

  a_cal_quiet: assert property (
    !cal_active_i && !(wr_i && addr_i == `ADDR_STATUS_THREE)
    |=> st.status_three[`CAL_ERROR_BIT]
        == $past(st.status_three[`CAL_ERROR_BIT]))
    else $error("cal error flag changed outside calibration");

  a_tone_hold: assert property (
    st.digit_valid && !(wr_i && addr_i == `ADDR_STATUS_THREE)
    |=> st.status_three[`TONE_DETECT_BIT]
        == $past(st.status_three[`TONE_DETECT_BIT]))
    else $error("tone flag changed during a held digit");

  c_indirect_write: cover property (
    st.phase == telephony_irq_pkg::IND_FINISH && st.op_write);
  c_indirect_read: cover property (
    st.phase == telephony_irq_pkg::IND_FINISH && !st.op_write);
  c_irq_raised: cover property ($rose(irq_o));
  c_cal_error: cover property (
    $rose(st.status_three[`CAL_ERROR_BIT]));
  c_tone_detect: cover property (
    $rose(st.status_three[`TONE_DETECT_BIT]));

endmodule // telephony_irq_dual_tone_signal_indirect_regs

// ==== telephony_irq_consts.svh ====
/*
  Register offsets, field positions, reset values and timing counts
  for the telephony interrupt and indirect access block.
  Assumes an 8-bit register port and a 25 MHz device clock.
*/
// Function
// - hook change during calibration sets cal error
// - finished indirect access sets done flag
// - detected tone digit sets tone flag
// - writing one clears only that flag
// - enable one masks the eight timer sources
// - enable two masks power alarms, loop, trip
// - enable three masks cal, indirect, tone
// - valid bit high while digit detected
// - decoded digit shown in low nibble
// - data then address writes indirect location
// - address alone reads indirect location
// - all these registers reset to zero
// - status one and two mirror enables
// - pending bit from address write to tick
// - high and low bytes form sixteen bits
`ifndef TELEPHONY_IRQ_CONSTS_SVH
`define TELEPHONY_IRQ_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_STATUS_ONE    8'h12
`define ADDR_STATUS_TWO    8'h13
`define ADDR_STATUS_THREE  8'h14
`define ADDR_ENABLE_ONE    8'h15
`define ADDR_ENABLE_TWO    8'h16
`define ADDR_ENABLE_THREE  8'h17
`define ADDR_TONE_STATUS   8'h18
`define ADDR_DATA_LOW      8'h1c
`define ADDR_DATA_HIGH     8'h1d
`define ADDR_IND_ADDRESS   8'h1e
`define ADDR_IND_STATUS    8'h1f

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CAL_ERROR_BIT      2
`define IND_DONE_BIT       1
`define TONE_DETECT_BIT    0
`define DIGIT_VALID_BIT    4
`define THREE_MASK         8'h07
`define REG_RESET          8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ             25000000
`define IND_RATE_HZ        16000
`define IND_TICK_CYCLES    (`CLK_HZ / `IND_RATE_HZ)

`endif

// ==== telephony_irq_pkg.sv ====
/*
  Types of the telephony interrupt and indirect access block.
  Assumes nothing beyond the constants header.
*/
package telephony_irq_pkg;

  typedef enum logic [1:0] {
    IND_IDLE,
    IND_WAIT_TICK,
    IND_FINISH
  } ind_phase_type;

  typedef struct packed {
    logic [7:0]    status_one;
    logic [7:0]    status_two;
    logic [7:0]    status_three;
    logic [7:0]    enable_one;
    logic [7:0]    enable_two;
    logic [7:0]    enable_three;
    logic          digit_valid;
    logic [3:0]    decoded_digit;
    logic          hook_prev;
    logic [7:0]    data_low;
    logic [7:0]    data_high;
    logic [7:0]    indirect_address;
    logic          indirect_pending;
    logic          data_dirty;
    logic          op_write;
    ind_phase_type phase;
    logic [7:0]    rdata;
  } regs_type;

  typedef struct packed {
    logic [10:0] count;
    logic        tick;
  } tick_type;

  typedef struct packed {
    logic [255:0][15:0] cells;
    logic [15:0]        rdata;
  } store_type;

endpackage

// ==== indirect_update_tick.sv ====
/*
  Free running 16 kHz update tick for indirect accesses.
  Assumes the 25 MHz device clock; the cycle count rounds down.
*/
`timescale 1ns/10ps
`include "telephony_irq_consts.svh"
module indirect_update_tick (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      tick_o
);
  localparam logic [10:0] LAST = 11'(`IND_TICK_CYCLES - 1);

  telephony_irq_pkg::tick_type st;
  telephony_irq_pkg::tick_type next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count == LAST)
    begin
      next_st.count = 11'h000;
      next_st.tick  = 1'b1;
    end
    else
    begin
      next_st.count = st.count + 11'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_o = st.tick;
endmodule // indirect_update_tick

// ==== indirect_store.sv ====
/*
  Indirect register store, 256 words of 16 bits, registered read.
  Assumes one-cycle write and read enables, never both at once.
*/
`timescale 1ns/10ps
module indirect_store (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o
);
  telephony_irq_pkg::store_type st;
  telephony_irq_pkg::store_type next_st;

  always_comb
  begin
    next_st = st;
    if (we_i)
      next_st.cells[addr_i] = wdata_i;
    if (re_i)
      next_st.rdata = st.cells[addr_i];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign rdata_o = st.rdata;
endmodule // indirect_store

// ==== telephony_irq_tb.sv ====
/*
  Self-checking bench for the telephony interrupt and indirect block:
  a model kept in integers is compared with every read but the pending polls, and with the irq level.
  Assumes the design's constants header and a 25 MHz clock.
*/
`timescale 1ns/10ps
`include "telephony_irq_consts.svh"
module testbench;
  logic       clk_i;
  logic       rstn_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic [7:0] timer_event_i;
  logic [7:0] alarm_event_i;
  logic       hook_state_i;
  logic       cal_active_i;
  logic       tone_valid_i;
  logic [3:0] tone_digit_i;
  logic       irq_o;
  int         fails;
  int         comparisons;
  int         seed;
  int         s1, s2, s3, e1, e2, e3, w, a1;
  int         mem [int];
  logic [7:0] v;
  logic [3:0] codes [15];

  telephony_irq_dual_tone_signal_indirect_regs dut (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .addr_i        (addr_i),
    .wdata_i       (wdata_i),
    .wr_i          (wr_i),
    .rd_i          (rd_i),
    .rdata_o       (rdata_o),
    .timer_event_i (timer_event_i),
    .alarm_event_i (alarm_event_i),
    .hook_state_i  (hook_state_i),
    .cal_active_i  (cal_active_i),
    .tone_valid_i  (tone_valid_i),
    .tone_digit_i  (tone_digit_i),
    .irq_o         (irq_o)
  );

  always #20 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  task automatic chkrd(input logic [7:0] a, input int exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp[7:0], "register read");
  endtask

  task automatic chkirq;
    logic [7:0] x;
    x = (((s1 & e1) | (s2 & e2) | (s3 & e3)) != 0) ? 8'h01 : 8'h00;
    chk({7'h00, irq_o}, x, "irq level");
  endtask

  task automatic ev(input logic [7:0] t, input logic [7:0] al);
    @(posedge clk_i);
    timer_event_i <= t;
    alarm_event_i <= al;
    @(posedge clk_i);
    timer_event_i <= 8'h00;
    alarm_event_i <= 8'h00;
    @(negedge clk_i);
    s1 = s1 | t;
    s2 = s2 | al;
    chkirq();
  endtask

  // one indirect access; a read loads the data bytes from the store
  task automatic ind(input int a, input int d, input bit write);
    int n;
    if (write)
    begin
      wr(`ADDR_DATA_LOW, d[7:0]);
      wr(`ADDR_DATA_HIGH, d[15:8]);
      mem[a] = d;
    end
    wr(`ADDR_IND_ADDRESS, a[7:0]);
    n = 0;
    do
    begin
      rd(`ADDR_IND_STATUS, v);
      n++;
    end while (v[0] !== 1'b0 && n < 1000);
    if (v[0] !== 1'b0)
    begin
      fails++;
      $display("[ERR] %0t indirect access never completed", $time);
      stop_test();
    end
    chk(v, 8'h00, "pending after tick");
    s3 = s3 | 2;
    chkrd(`ADDR_STATUS_THREE, s3);
    chkirq();
    d = mem.exists(a) ? mem[a] : 0;
    chkrd(`ADDR_DATA_LOW, d & 8'hff);
    chkrd(`ADDR_DATA_HIGH, (d >> 8) & 8'hff);
    wr(`ADDR_STATUS_THREE, 8'h02);
    s3 = s3 & ~2;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    timer_event_i = 8'h00;
    alarm_event_i = 8'h00;
    hook_state_i = 1'b0;
    cal_active_i = 1'b0;
    tone_valid_i = 1'b0;
    tone_digit_i = 4'h0;
    fails = 0;
    comparisons = 0;
    seed = 62;
    {s1, s2, s3, e1, e2, e3} = {6{32'sd0}};
    codes = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
              4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf, 4'h0};
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (codes[k])
      if (k < 10)
        chkrd(`ADDR_STATUS_ONE + k, 0);
    chkrd(8'h00, 0);
    e1 = $random(seed) & 8'hff;
    e2 = $random(seed) & 8'hff;
    e3 = $random(seed) & 8'hff;
    wr(`ADDR_ENABLE_ONE, e1[7:0]);
    wr(`ADDR_ENABLE_TWO, e2[7:0]);
    wr(`ADDR_ENABLE_THREE, e3[7:0]);
    e3 = e3 & `THREE_MASK;
    chkrd(`ADDR_ENABLE_ONE, e1);
    chkrd(`ADDR_ENABLE_TWO, e2);
    chkrd(`ADDR_ENABLE_THREE, e3);
    wr(`ADDR_TONE_STATUS, 8'hff);
    chkrd(`ADDR_TONE_STATUS, 0);
    repeat (4)
    begin
      ev($random(seed), $random(seed));
      chkrd(`ADDR_STATUS_ONE, s1);
      chkrd(`ADDR_STATUS_TWO, s2);
      w = $random(seed) & 8'hff;
      wr(`ADDR_STATUS_ONE, w[7:0]);
      s1 = s1 & ~w;
      chkrd(`ADDR_STATUS_ONE, s1);
      chkirq();
    end
    wr(`ADDR_STATUS_ONE, 8'hff);
    wr(`ADDR_STATUS_TWO, 8'hff);
    {s1, s2} = {2{32'sd0}};
    wr(`ADDR_ENABLE_THREE, 8'hff);
    e3 = 7;
    // hook change counts only while calibration runs
    @(posedge clk_i);
    cal_active_i <= 1'b1;
    @(posedge clk_i);
    hook_state_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    s3 = s3 | 4;
    chkrd(`ADDR_STATUS_THREE, s3);
    chkirq();
    wr(`ADDR_STATUS_THREE, 8'h04);
    s3 = s3 & ~4;
    cal_active_i <= 1'b0;
    @(posedge clk_i);
    hook_state_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chkrd(`ADDR_STATUS_THREE, s3);
    foreach (codes[k])
    begin
      @(posedge clk_i);
      tone_digit_i <= codes[k];
      tone_valid_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chkrd(`ADDR_TONE_STATUS, {4'h1, codes[k]});
      s3 = s3 | 1;
      chkrd(`ADDR_STATUS_THREE, s3);
      chkirq();
      wr(`ADDR_STATUS_THREE, 8'hfe);
      chkrd(`ADDR_STATUS_THREE, s3);
      @(posedge clk_i);
      tone_valid_i <= 1'b0;
      wr(`ADDR_STATUS_THREE, 8'h01);
      s3 = s3 & ~1;
      chkrd(`ADDR_TONE_STATUS, {4'h0, codes[k]});
    end
    a1 = $random(seed) & 8'hff;
    ind(a1, $random(seed) & 16'hffff, 1'b1);
    ind(a1 ^ 1, $random(seed) & 16'hffff, 1'b1);
    ind(a1, 0, 1'b0);
    ind(a1 ^ 1, 0, 1'b0);
    ind(a1 ^ 2, 0, 1'b0);
    stop_test();
  end
endmodule // testbench
